// [rtl/espc_regs.svh]
// Register offsets, field positions, reset values and timing counts of the sync conditioner
`ifndef ESPC_REGS_SVH
`define ESPC_REGS_SVH

// Byte offsets of the register words
`define ESPC_OFS_CTRL 8'h00
`define ESPC_OFS_DEBOUNCE 8'h04
`define ESPC_OFS_MINTIME 8'h08
`define ESPC_OFS_DIV1 8'h0c
`define ESPC_OFS_DIV2 8'h10
`define ESPC_OFS_DIV3 8'h14
`define ESPC_OFS_DIV4 8'h18
`define ESPC_OFS_STATUS 8'h1c

// Control word fields
`define ESPC_CTRL_TERM_LSB 0
`define ESPC_CTRL_TERM_MSB 2
`define ESPC_CTRL_RISING_BIT 3
`define ESPC_CTRL_EXT_LSB 4
`define ESPC_CTRL_EXT_MSB 6

// Status word fields
`define ESPC_STAT_LEVEL_BIT 0
`define ESPC_STAT_LOCK_BIT 1
`define ESPC_STAT_RAW_BIT 2
`define ESPC_STAT_CNT_LSB 16
`define ESPC_STAT_CNT_MSB 31

// Reset values
`define ESPC_RST_CTRL 8'h00
`define ESPC_RST_DEBOUNCE 8'h01
`define ESPC_RST_MINTIME 16'h0000
`define ESPC_RST_DIV1 16'h0009
`define ESPC_RST_DIV 8'h00

// Timing: clock rate, lockout time unit in microseconds, derived cycle count
`define ESPC_CLK_HZ 10000000
`define ESPC_LOCK_UNIT_US 1
`define ESPC_LOCK_UNIT_CYC ((`ESPC_CLK_HZ / 1000000) * `ESPC_LOCK_UNIT_US)

`endif

// [rtl/espc_pkg.sv]
// Types shared by the sync conditioner modules
package espc_pkg;

    // Lockout state, Gray coded along watch -> hold -> watch
    typedef enum logic [0:0] {
        ESPC_WATCH = 1'b0,
        ESPC_HOLD = 1'b1
    } espc_lock_t;

    typedef logic [7:0] espc_din_t;

endpackage : espc_pkg

// [rtl/espc_input_sync.sv]
// Two-stage synchronisers for the digital input terminals, followed by the terminal selector
`timescale 1ns/100ps
module espc_input_sync
    import espc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire espc_din_t din_i,
    input wire logic [2:0] term_sel_i,
    output logic sel_level_o,
    output logic first_level_o
);

    espc_din_t meta;
    espc_din_t sync;

    // One synchroniser per terminal; the first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta[g] <= 1'b0;
                    sync[g] <= 1'b0;
                end else begin
                    meta[g] <= din_i[g];
                    sync[g] <= meta[g];
                end
            end
        end
    endgenerate

    // Terminal choice; terminal 0 stays visible on its own for time sync
    assign sel_level_o = sync[term_sel_i];
    assign first_level_o = sync[0];

endmodule : espc_input_sync

// [rtl/espc_debounce.sv]
// Debounce filter: a new level counts only after enough agreeing samples
`timescale 1ns/100ps
module espc_debounce
    import espc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sample_i,
    input wire logic [7:0] count_i,
    input wire logic rising_i,
    output logic level_o,
    output logic edge_o
);

    logic [7:0] run;
    logic [1:0] settle;
    logic [8:0] need;
    logic [8:0] next_run;
    logic accept;

    // A count of zero behaves as one so the filter never stalls
    assign need = (count_i == 8'h00) ? 9'h001 : {1'b0, count_i};
    assign next_run = {1'b0, run} + 9'h001;
    assign accept = (settle == 2'h3) && (sample_i != level_o) && (next_run >= need);

    // Level primes over three samples after reset without an edge; the synchroniser
    // still shows its reset zero for two of them, so a pin already at the slope
    // level would otherwise give a false event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
            run <= 8'h00;
            settle <= 2'h0;
            edge_o <= 1'b0;
        end else begin
            edge_o <= 1'b0;
            if (settle != 2'h3) begin
                level_o <= sample_i;
                settle <= settle + 2'h1;
                run <= 8'h00;
            end else if (sample_i == level_o) begin
                run <= 8'h00;
            end else if (accept) begin
                level_o <= sample_i;
                run <= 8'h00;
                edge_o <= (sample_i == rising_i);
            end else begin
                run <= next_run[7:0];
            end
        end
    end

endmodule : espc_debounce

// [rtl/espc_top.sv]
// External sync pulse conditioner with Wishbone register access
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`include "espc_regs.svh"

// Operation
// - Sync input chosen among digital terminals; first terminal also feeds time sync.
// - Configuration picks rising or falling transition as the sync event.
// - New level accepted only after configured count of agreeing samples.
// - After an accepted edge, further edges ignored until minimum time elapses.
// - Sample rate one always runs internally, never from the external sync.
// - Only sample rates two to four may follow the external sync.
module espc_top
    import espc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire espc_din_t din_i,
    output logic [3:0] sample_strobe_o,
    output logic time_sync_o
);

    localparam logic [3:0] UNIT_LAST = 4'(`ESPC_LOCK_UNIT_CYC - 1);

    // Address match on the word part of the byte address
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    // Byte-lane merge for a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        integer i;
        r = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // Configuration registers
    logic [7:0] ctrl;
    logic [7:0] debounce;
    logic [15:0] min_time;
    logic [15:0] div1;
    logic [7:0] div_hi [1:3];

    // Lockout and event state
    espc_lock_t lock_state;
    logic [15:0] lock_left;
    logic [3:0] unit_cnt;
    logic [15:0] edge_count;

    // Internal rate generator state
    logic [15:0] base_cnt;
    logic [7:0] sub_cnt [1:3];
    logic [3:0] int_tick;

    // Bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i;
    wire wr_ctrl = bus_wr && hit(wb_adr_i, `ESPC_OFS_CTRL);
    wire wr_deb = bus_wr && hit(wb_adr_i, `ESPC_OFS_DEBOUNCE);
    wire wr_min = bus_wr && hit(wb_adr_i, `ESPC_OFS_MINTIME);
    wire wr_div1 = bus_wr && hit(wb_adr_i, `ESPC_OFS_DIV1);
    wire [3:1] wr_div;
    assign wr_div[1] = bus_wr && hit(wb_adr_i, `ESPC_OFS_DIV2);
    assign wr_div[2] = bus_wr && hit(wb_adr_i, `ESPC_OFS_DIV3);
    assign wr_div[3] = bus_wr && hit(wb_adr_i, `ESPC_OFS_DIV4);

    // Write data merged per register width
    wire [31:0] next_ctrl = merge({24'h000000, ctrl}, wb_dat_i, wb_sel_i);
    wire [31:0] next_deb = merge({24'h000000, debounce}, wb_dat_i, wb_sel_i);
    wire [31:0] next_min = merge({16'h0000, min_time}, wb_dat_i, wb_sel_i);
    wire [31:0] next_div1 = merge({16'h0000, div1}, wb_dat_i, wb_sel_i);

    // Control fields
    wire [2:0] term_sel = ctrl[`ESPC_CTRL_TERM_MSB:`ESPC_CTRL_TERM_LSB];
    wire slope_rising = ctrl[`ESPC_CTRL_RISING_BIT];
    wire [3:1] ext_en = ctrl[`ESPC_CTRL_EXT_MSB:`ESPC_CTRL_EXT_LSB];

    // Input path
    logic sel_level;
    logic first_level;
    logic deb_level;
    logic deb_edge;

    espc_input_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .din_i(din_i),
        .term_sel_i(term_sel),
        .sel_level_o(sel_level),
        .first_level_o(first_level)
    );

    espc_debounce u_deb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_i(sel_level),
        .count_i(debounce),
        .rising_i(slope_rising),
        .level_o(deb_level),
        .edge_o(deb_edge)
    );

    // only edges seen while watching count
    wire sync_event = deb_edge && (lock_state == ESPC_WATCH);
    wire unit_done = (unit_cnt == UNIT_LAST);

    // Configuration writes; unmapped writes are acknowledged and dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `ESPC_RST_CTRL;
            debounce <= `ESPC_RST_DEBOUNCE;
            min_time <= `ESPC_RST_MINTIME;
            div1 <= `ESPC_RST_DIV1;
        end else begin
            if (wr_ctrl) begin
                // no external bit for rate one
                ctrl <= {1'b0, next_ctrl[6:0]};
            end
            if (wr_deb) begin
                debounce <= next_deb[7:0];
            end
            if (wr_min) begin
                min_time <= next_min[15:0];
            end
            if (wr_div1) begin
                div1 <= next_div1[15:0];
            end
        end
    end

    // Divisor registers of rates two to four
    genvar g;
    generate
        for (g = 1; g < 4; g = g + 1) begin : g_div
            wire [31:0] next_div = merge({24'h000000, div_hi[g]}, wb_dat_i, wb_sel_i);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    div_hi[g] <= `ESPC_RST_DIV;
                end else if (wr_div[g]) begin
                    div_hi[g] <= next_div[7:0];
                end
            end
        end
    endgenerate

    // Lockout timer in whole time units after each accepted edge
    // minimum time lockout
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_state <= ESPC_WATCH;
            lock_left <= 16'h0000;
            unit_cnt <= 4'h0;
        end else begin
            case (lock_state)
                ESPC_WATCH: begin
                    unit_cnt <= 4'h0;
                    if (sync_event && (min_time != 16'h0000)) begin
                        lock_state <= ESPC_HOLD;
                        lock_left <= min_time;
                    end
                end
                ESPC_HOLD: begin
                    if (unit_done) begin
                        unit_cnt <= 4'h0;
                        lock_left <= lock_left - 16'h0001;
                        if (lock_left == 16'h0001) begin
                            lock_state <= ESPC_WATCH;
                        end
                    end else begin
                        unit_cnt <= unit_cnt + 4'h1;
                    end
                end
                default: begin
                    lock_state <= ESPC_WATCH;
                end
            endcase
        end
    end

    // Count of accepted sync edges, wraps; handy for software to see pulses arrive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_count <= 16'h0000;
        end else if (sync_event) begin
            edge_count <= edge_count + 16'h0001;
        end
    end

    // Base cycle: rate one divides the clock by div1 + 1
    // internal base rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_cnt <= 16'h0000;
        end else if (base_cnt >= div1) begin
            base_cnt <= 16'h0000;
        end else begin
            base_cnt <= base_cnt + 16'h0001;
        end
    end
    assign int_tick[0] = (base_cnt >= div1);

    // Rates two to four divide the base tick by their divisor + 1
    generate
        for (g = 1; g < 4; g = g + 1) begin : g_rate
            assign int_tick[g] = int_tick[0] && (sub_cnt[g] >= div_hi[g]);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sub_cnt[g] <= 8'h00;
                end else if (int_tick[g]) begin
                    sub_cnt[g] <= 8'h00;
                end else if (int_tick[0]) begin
                    sub_cnt[g] <= sub_cnt[g] + 8'h01;
                end
            end
        end
    endgenerate

    // Sample strobes; external sync replaces the internal tick of rates two to four
    // external source choice
    wire [3:0] next_strobe = {ext_en[3] ? sync_event : int_tick[3],
                              ext_en[2] ? sync_event : int_tick[2],
                              ext_en[1] ? sync_event : int_tick[1],
                              int_tick[0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_strobe_o <= 4'h0;
            time_sync_o <= 1'b0;
        end else begin
            sample_strobe_o <= next_strobe;
            time_sync_o <= first_level;
        end
    end

    // Read mux; unmapped words read zero
    wire [31:0] status_word = {edge_count, 13'h0000, sel_level,
                               (lock_state == ESPC_HOLD), deb_level};
    wire [31:0] rd_div2 = {24'h000000, div_hi[1]};
    wire [31:0] rd_div3 = {24'h000000, div_hi[2]};
    wire [31:0] rd_div4 = {24'h000000, div_hi[3]};
    wire [31:0] next_rdata =
        hit(wb_adr_i, `ESPC_OFS_CTRL) ? {24'h000000, ctrl} :
        hit(wb_adr_i, `ESPC_OFS_DEBOUNCE) ? {24'h000000, debounce} :
        hit(wb_adr_i, `ESPC_OFS_MINTIME) ? {16'h0000, min_time} :
        hit(wb_adr_i, `ESPC_OFS_DIV1) ? {16'h0000, div1} :
        hit(wb_adr_i, `ESPC_OFS_DIV2) ? rd_div2 :
        hit(wb_adr_i, `ESPC_OFS_DIV3) ? rd_div3 :
        hit(wb_adr_i, `ESPC_OFS_DIV4) ? rd_div4 :
        hit(wb_adr_i, `ESPC_OFS_STATUS) ? status_word : 32'h00000000;

    // Classic single-cycle answer: ack one cycle after the request, then dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

endmodule : espc_top

// [dv/espc_assertions.sv]
// Port-level checker for the sync conditioner
`timescale 1ns/100ps
module espc_assertions
    import espc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire espc_din_t din_i,
    input wire logic [3:0] sample_strobe_o,
    input wire logic time_sync_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // A request is taken while no answer is pending
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;

    property p_ack_lat;
        take |=> wb_ack_o;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after take"); // bus
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle"); // bus
    property p_ack_req;
        wb_ack_o |-> $past(take);
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without a request"); // bus
    property p_dat_hold;
        $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i;
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved outside a read"); // bus
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i[7:5] != 3'h0 |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // bus
    // Base rate keeps its internal period whatever the control word says
    property p_rate1;
        sample_strobe_o[0] |=> (!sample_strobe_o[0])[*8] ##1 !sample_strobe_o[0]
            ##1 sample_strobe_o[0];
    endproperty
    a_rate1: assert property (p_rate1) else $error("base rate period wrong");
    // Margin of five samples covers synchroniser plus output register
    property p_sync;
        $stable(din_i[0])[*5] |-> time_sync_o == din_i[0];
    endproperty
    a_sync: assert property (p_sync) else $error("time sync does not follow input");
    property p_strobe_one;
        sample_strobe_o[1] |=> !sample_strobe_o[1];
    endproperty
    a_strobe_one: assert property (p_strobe_one) else $error("strobe wider than one");
endmodule : espc_assertions

bind espc_top espc_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din_i(din_i),
    .sample_strobe_o(sample_strobe_o), .time_sync_o(time_sync_o));

// [dv/espc_pulse_src.sv]
// Sensor pulse source model driving the digital input terminals
`timescale 1ns/100ps
module espc_pulse_src
    import espc_pkg::*;
(
    input wire logic clk_i,
    input wire logic [2:0] term_i,
    input wire logic level_i,
    input wire logic chatter_i,
    output espc_din_t din_o
);
    logic flip = 1'b0;
    espc_din_t pat;

    // Unselected terminals carry the inverse, so a wrong selection shows the wrong slope
    always_comb begin
        pat = ~{8{level_i}};
        pat[term_i] = chatter_i ? flip : level_i; // Chatter toggles every cycle
    end

    // One update of the terminals per edge
    initial din_o = 8'h01;
    always @(posedge clk_i) begin
        flip <= ~flip;
        din_o <= pat;
    end
endmodule : espc_pulse_src

// [dv/testbench.sv]
// Self-checking bench for the sync conditioner
`timescale 1ns/100ps
module testbench
    import espc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic ack;
    logic tsync;
    logic [3:0] strb;
    espc_din_t din;
    logic [2:0] term = 3'h0;
    logic lvl = 1'b1;
    logic chat = 1'b0;
    int num_errors = 0;
    int cmp_count = 0;
    int cnt [4] = '{0, 0, 0, 0};

    espc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .din_i(din), .sample_strobe_o(strb), .time_sync_o(tsync));
    espc_pulse_src src_u (.clk_i(clk_i), .term_i(term), .level_i(lvl), .chatter_i(chat),
        .din_o(din));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // Strobe tallies for the external rates
    always @(posedge clk_i) begin
        for (int i = 1; i < 4; i++) if (strb[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One classic cycle; waits for ack, only the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rd, e);
    endtask : rdc

    // Holds the source level for a given number of cycles
    task automatic drv(input logic l, input int hold);
        @(posedge clk_i);
        lvl <= l;
        repeat (hold - 1) @(posedge clk_i);
    endtask : drv

    task automatic t_regs;
        logic [7:0] ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
            8'h20, 8'hfc};
        logic [31:0] rv [10] = '{32'h0, 32'h1, 32'h0, 32'h9, 32'h0, 32'h0, 32'h0, 32'h5,
            32'h0, 32'h0};
        for (int i = 0; i < 10; i++) rdc(ofs[i], rv[i]);
        wr(8'h00, 32'hff);
        rdc(8'h00, 32'h7f);
        bus(1'b1, 8'h04, 32'hff, 4'h0);
        rdc(8'h04, 32'h1);
        wr(8'h10, 32'h1ff);
        rdc(8'h10, 32'hff);
        wr(8'h40, 32'hffffffff);
        rdc(8'h40, 32'h0);
        wr(8'h10, 32'h0);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_slope;
        int base;
        for (int t = 0; t < 8; t++) begin
            for (int r = 0; r < 2; r++) begin
                term <= 3'(t);
                wr(8'h00, 32'h10 | (r << 3) | t);
                repeat (8) @(posedge clk_i);
                base = cnt[1];
                drv(1'b0, 12);
                chk(cnt[1] - base, 32'(1 - r));
                drv(1'b1, 12);
                chk(cnt[1] - base, 32'h1);
            end
        end
        $display("t_slope done");
    endtask : t_slope

    task automatic t_deb;
        int base;
        term <= 3'h0;
        wr(8'h00, 32'h10);
        wr(8'h04, 32'h4);
        repeat (10) @(posedge clk_i);
        base = cnt[1];
        drv(1'b0, 3);
        drv(1'b1, 10);
        chk(cnt[1] - base, 32'h0);
        chk({31'h0, tsync}, 32'h1);
        drv(1'b0, 4);
        drv(1'b1, 10);
        chk(cnt[1] - base, 32'h1);
        chat <= 1'b1;
        repeat (12) @(posedge clk_i);
        chat <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk(cnt[1] - base, 32'h1);
        wr(8'h04, 32'h1);
        $display("t_deb done");
    endtask : t_deb

    task automatic t_lock;
        int b [4];
        wr(8'h00, 32'h70);
        wr(8'h08, 32'h3);
        repeat (40) @(posedge clk_i);
        b = cnt;
        drv(1'b0, 5);
        drv(1'b1, 5);
        drv(1'b0, 5);
        drv(1'b1, 5);
        for (int i = 1; i < 4; i++) chk(cnt[i] - b[i], 32'h1);
        drv(1'b1, 30);
        drv(1'b0, 10);
        chk({31'h0, tsync}, 32'h0);
        drv(1'b1, 10);
        for (int i = 1; i < 4; i++) chk(cnt[i] - b[i], 32'h2);
        wr(8'h08, 32'h0);
        $display("t_lock done");
    endtask : t_lock

    task automatic conclude;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_slope;
        t_deb;
        t_lock;
        conclude;
    end

    // Run needs under a thousand cycles; this is 50000 cycles, over fifty times that
    initial begin
        #5000000;
        num_errors++;
        conclude;
    end
endmodule : testbench
